/* rtl/vram_serial_buffer_transfer.sv */
`include "vsbt_regs.svh"

module vram_serial_buffer_transfer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic warn_pulse,
  output logic error_pulse,
  output vsbt_pkg::event_type last_event
);
  import vsbt_pkg::*;

  localparam int WAKE_CYCLES = (`VSBT_WAKE_NS + `VSBT_CLK_NS - 1) / `VSBT_CLK_NS;
  localparam int TICK_CYCLES = `VSBT_REFRESH_TICK_NS / `VSBT_CLK_NS;

  // =========================================================================
  // storage
  logic [7:0] sam_mem [`VSBT_SAM_WORDS];
  logic [`VSBT_SAM_WORDS-1:0] sam_valid;
  logic [7:0] dram_mem [`VSBT_ROWS][`VSBT_SAM_WORDS];
  logic [`VSBT_SAM_WORDS-1:0] dram_valid [`VSBT_ROWS];
  logic [2:0] row_age [`VSBT_ROWS];
  ctrl_type ctrl;
  subst_type subst;
  peek_type peek;
  logic [7:0] wmask;
  logic [3:0] ptr;
  logic [3:0] lower_tap;
  logic [3:0] upper_tap;
  logic [15:0] serial_out;
  logic [7:0] wake_count;
  logic awake;
  logic [7:0] tick_count;
  logic refresh_tick;

  // =========================================================================
  // bus slave
  bus_state_type wr_state;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_mapped;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign do_write = aw_full && w_full && (wr_state == BUS_IDLE);

  always_comb begin
    unique case (aw_addr)
      `VSBT_OFF_CTRL, `VSBT_OFF_CMD, `VSBT_OFF_WMASK, `VSBT_OFF_SUBST, `VSBT_OFF_SAMLD,
      `VSBT_OFF_PEEK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // address and data are taken in either order; the write acts once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= BUS_IDLE;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `VSBT_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      unique case (wr_state)
        BUS_IDLE: begin
          awready <= !aw_full && !(awvalid && awready);
          wready <= !w_full && !(wvalid && wready);
          if (awvalid && awready) begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
          end
          if (wvalid && wready) begin
            w_full <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
          end
          if (do_write) begin
            wr_state <= BUS_RESP;
            bvalid <= 1'b1;
            bresp <= wr_mapped ? `VSBT_RESP_OKAY : `VSBT_RESP_SLVERR;
            aw_full <= 1'b0;
            w_full <= 1'b0;
          end
        end
        BUS_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            wr_state <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  // =========================================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ctrl_type'(`VSBT_CTRL_RESET);
      subst <= subst_type'(`VSBT_SUBST_RESET);
      wmask <= `VSBT_WMASK_RESET;
      peek <= '0;
    end else if (do_write) begin
      unique case (aw_addr)
        `VSBT_OFF_CTRL: ctrl <= ctrl_type'(merge(ctrl, w_data, w_strb));
        `VSBT_OFF_SUBST: subst <= subst_type'(merge(subst, w_data, w_strb));
        `VSBT_OFF_WMASK: wmask <= w_strb[0] ? w_data[7:0] : wmask;
        `VSBT_OFF_PEEK: peek <= peek_type'(merge(peek, w_data, w_strb));
        default: ;
      endcase
    end
  end

  // =========================================================================
  // command decode
  command_type cmd;
  sam_load_type sam_load;
  logic is_cmd;
  logic exec_read;
  logic xfer_req;
  logic xfer_ok;
  logic bad_seg;
  logic half_dst_upper;
  logic [3:0] row_idx;
  logic row_mapped;
  logic row_wide;
  logic row_expired;
  logic [7:0] sam_at_ptr;
  logic [15:0] next_serial_out;
  logic data_mapped;
  logic [3:0] next_ptr;
  event_type ev;

  assign cmd = command_type'(merge(32'h00000000, w_data, w_strb));
  assign sam_load = sam_load_type'(w_data);
  assign is_cmd = do_write && (aw_addr == `VSBT_OFF_CMD);
  // a transfer in the same command takes precedence over a read
  assign exec_read = is_cmd && cmd.go_read && !cmd.go_transfer && ctrl.is_vram;
  assign xfer_req = is_cmd && cmd.go_transfer && ctrl.is_vram;
  assign bad_seg = ctrl.half_size ? (cmd.row_segment != SEG_LOWER && cmd.row_segment != SEG_UPPER)
                                  : (cmd.row_segment > SEG_UPPER);
  assign xfer_ok = xfer_req && awake && !bad_seg;
  assign half_dst_upper = (cmd.row_segment == SEG_UPPER);
  assign sam_at_ptr = sam_mem[ptr];
  assign row_expired = (row_age[row_idx] == `VSBT_AGE_MAX);

  // row vector: bit 0 is the rightmost, msb the leftmost
  always_comb begin
    row_idx = 4'h0;
    row_mapped = 1'b0;
    for (int i = 0; i < `VSBT_ROW_BITS; i++) begin
      if (3'(i) >= cmd.row_len || cmd.row_unknown[i]) begin
        row_idx[i] = subst.addr_fill[i];
        row_mapped = 1'b1;
      end else begin
        row_idx[i] = cmd.row_vec[i];
      end
    end
    row_wide = cmd.row_len > `VSBT_ROW_LEN_NEEDED;
  end

  // output word shaped to the requested width
  always_comb begin
    next_serial_out = 16'h0000;
    for (int i = 0; i < `VSBT_OUT_BITS; i++) begin
      if (5'(i) < subst.out_width) begin
        if (i < `VSBT_WORD_BITS && sam_valid[ptr]) begin
          next_serial_out[i] = sam_at_ptr[i];
        end else begin
          next_serial_out[i] = subst.data_fill;
        end
      end
    end
    data_mapped = (subst.out_width > `VSBT_OUT_NATIVE) || (!sam_valid[ptr] && subst.out_width != 5'h00);
  end

  always_comb begin
    if (ctrl.split_mode && ptr[2:0] == `VSBT_HALF_TOP) begin
      next_ptr = ptr[3] ? lower_tap : upper_tap;
    end else begin
      next_ptr = ptr + 4'h1;
    end
  end

  always_comb begin
    ev = '0;
    ev.bad_width = exec_read && (subst.out_width != `VSBT_OUT_NATIVE);
    ev.data_mapped = exec_read && data_mapped;
    ev.not_vram = is_cmd && (cmd.go_read || cmd.go_transfer) && !ctrl.is_vram;
    ev.asleep = xfer_req && !awake;
    ev.bad_segment = xfer_req && awake && bad_seg;
    ev.seg_forced = xfer_ok && !ctrl.half_size && cmd.row_segment != SEG_FULL;
    ev.ptr_clamped = xfer_ok && cmd.serial_ptr > {1'b0, `VSBT_SAM_TOP};
    ev.row_expired = xfer_ok && row_expired;
    ev.row_too_wide = xfer_ok && row_wide;
    ev.row_mapped = xfer_ok && row_mapped;
  end

  // =========================================================================
  // events: errors always pulse, warnings only when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_pulse <= 1'b0;
      error_pulse <= 1'b0;
      last_event <= '0;
    end else begin
      warn_pulse <= ctrl.warning_enable && (ev.bad_width || ev.data_mapped || ev.asleep || ev.seg_forced ||
                    ev.ptr_clamped || ev.row_expired || ev.row_too_wide || ev.row_mapped);
      error_pulse <= ev.not_vram || ev.bad_segment;
      if (is_cmd) begin
        last_event <= ev;
      end
    end
  end

  // =========================================================================
  // wake-up and refresh timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_count <= 8'h00;
      awake <= 1'b0;
      tick_count <= 8'h00;
      refresh_tick <= 1'b0;
    end else begin
      if (!awake) begin
        wake_count <= wake_count + 8'h01;
        awake <= (wake_count == 8'(WAKE_CYCLES - 1));
      end
      refresh_tick <= (tick_count == 8'(TICK_CYCLES - 1));
      tick_count <= (tick_count == 8'(TICK_CYCLES - 1)) ? 8'h00 : tick_count + 8'h01;
    end
  end

  // ages saturate at the expiry mark; only a transfer brings a row back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < `VSBT_ROWS; r++) begin
        row_age[r] <= 3'h0;
      end
    end else begin
      for (int r = 0; r < `VSBT_ROWS; r++) begin
        if (xfer_ok && row_idx == 4'(r)) begin
          row_age[r] <= 3'h0;
        end else if (refresh_tick && row_age[r] != `VSBT_AGE_MAX) begin
          row_age[r] <= row_age[r] + 3'h1;
        end
      end
    end
  end

  // =========================================================================
  // serial position and taps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= `VSBT_LOWER_BASE;
      lower_tap <= `VSBT_LOWER_BASE;
      upper_tap <= `VSBT_UPPER_BASE;
      serial_out <= 16'h0000;
    end else if (exec_read) begin
      serial_out <= next_serial_out;
      ptr <= next_ptr;
      if (lower_tap == ptr) begin
        lower_tap <= `VSBT_LOWER_BASE;
      end
      if (upper_tap == ptr) begin
        upper_tap <= `VSBT_UPPER_BASE;
      end
    end else if (xfer_ok) begin
      if (cmd.serial_ptr > {1'b0, `VSBT_SAM_TOP}) begin
        ptr <= `VSBT_SAM_TOP;
        upper_tap <= `VSBT_SAM_TOP;
      end else begin
        ptr <= cmd.serial_ptr[3:0];
        if (cmd.serial_ptr[3]) begin
          upper_tap <= cmd.serial_ptr[3:0];
        end else begin
          lower_tap <= cmd.serial_ptr[3:0];
        end
      end
    end
  end

  // =========================================================================
  // serial buffer loading (software fill port)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sam_valid <= 16'h0000;
    end else if (do_write && aw_addr == `VSBT_OFF_SAMLD) begin
      sam_valid[sam_load.index] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_write && aw_addr == `VSBT_OFF_SAMLD) begin
      sam_mem[sam_load.index] <= sam_load.data;
    end
  end

  // =========================================================================
  // buffer to row transfer
  always_ff @(posedge aclk) begin
    if (xfer_ok) begin
      for (int w = 0; w < `VSBT_SAM_WORDS; w++) begin
        if (!ctrl.half_size || (w >= `VSBT_HALF_WORDS) == half_dst_upper) begin
          if (cmd.write_per_bit) begin
            dram_mem[row_idx][w] <= (dram_mem[row_idx][w] & ~wmask) |
                                    (sam_mem[ctrl.half_size ? w % `VSBT_HALF_WORDS : w] & wmask);
          end else begin
            dram_mem[row_idx][w] <= sam_mem[ctrl.half_size ? w % `VSBT_HALF_WORDS : w];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < `VSBT_ROWS; r++) begin
        dram_valid[r] <= 16'h0000;
      end
    end else if (xfer_ok) begin
      for (int w = 0; w < `VSBT_SAM_WORDS; w++) begin
        if (!ctrl.half_size || (w >= `VSBT_HALF_WORDS) == half_dst_upper) begin
          dram_valid[row_idx][w] <= sam_valid[ctrl.half_size ? w % `VSBT_HALF_WORDS : w] &&
                                    (!cmd.write_per_bit || (dram_valid[row_idx][w] && !row_expired));
        end else if (row_expired) begin
          dram_valid[row_idx][w] <= 1'b0;
        end
      end
    end
  end

  // =========================================================================
  // read channel: answer one cycle after the address is taken
  logic [31:0] rd_value;
  logic rd_mapped;

  always_comb begin
    rd_mapped = 1'b1;
    unique case (araddr)
      `VSBT_OFF_CTRL: rd_value = ctrl;
      `VSBT_OFF_WMASK: rd_value = {24'h000000, wmask};
      `VSBT_OFF_SUBST: rd_value = subst;
      `VSBT_OFF_STATUS: rd_value = {7'h00, awake, 4'h0, upper_tap, 4'h0, lower_tap, 4'h0, ptr};
      `VSBT_OFF_RDATA: rd_value = {16'h0000, serial_out};
      `VSBT_OFF_PEEK: rd_value = {23'h000000, dram_valid[peek.row][peek.word], dram_mem[peek.row][peek.word]};
      `VSBT_OFF_EVENT: rd_value = last_event;
      `VSBT_OFF_CMD, `VSBT_OFF_SAMLD: rd_value = 32'h00000000;
      default: begin
        rd_value = 32'h00000000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `VSBT_RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_mapped ? `VSBT_RESP_OKAY : `VSBT_RESP_SLVERR;
    end else begin
      arready <= 1'b1;
    end
  end

  // =========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_read_word;
    exec_read && sam_valid[ptr] && subst.out_width == `VSBT_OUT_NATIVE |=> serial_out == {8'h00, $past(sam_at_ptr)};
  endproperty
  a_read_word: assert property (p_read_word) else $error("serial read returned wrong word");

  property p_tap_clear;
    exec_read && !ptr[3] && lower_tap == ptr |=> lower_tap == `VSBT_LOWER_BASE;
  endproperty
  a_tap_clear: assert property (p_tap_clear) else $error("lower tap not cleared on read");

  property p_advance;
    exec_read && !ctrl.split_mode |=> ptr == $past(ptr) + 4'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("serial position did not advance by one");

  property p_half_jump;
    exec_read && ctrl.split_mode && ptr == {1'b0, `VSBT_HALF_TOP} |=> ptr == $past(upper_tap);
  endproperty
  a_half_jump: assert property (p_half_jump) else $error("split read did not jump to upper tap");

  property p_no_refresh;
    exec_read && !refresh_tick |=> row_age[0] == $past(row_age[0]);
  endproperty
  a_no_refresh: assert property (p_no_refresh) else $error("serial read changed a row age");

  property p_clamp;
    xfer_ok && cmd.serial_ptr > {1'b0, `VSBT_SAM_TOP} |=>
      ptr == `VSBT_SAM_TOP && upper_tap == `VSBT_SAM_TOP ##1 last_event.ptr_clamped;
  endproperty
  a_clamp: assert property (p_clamp) else $error("serial address not clamped");

  property p_asleep;
    xfer_req && !awake |=> $stable(ptr) && last_event.asleep && (warn_pulse == $past(ctrl.warning_enable));
  endproperty
  a_asleep: assert property (p_asleep) else $error("transfer before wake-up was not refused");

  property p_refresh_row;
    xfer_ok |=> row_age[$past(row_idx)] == 3'h0;
  endproperty
  a_refresh_row: assert property (p_refresh_row) else $error("target row not refreshed");

  property p_not_vram;
    is_cmd && cmd.go_transfer && !ctrl.is_vram |=> error_pulse && $stable(ptr) ##1 !error_pulse;
  endproperty
  a_not_vram: assert property (p_not_vram) else $error("non-video memory access not trapped");

  property p_warn_mute;
    warn_pulse |-> $past(ctrl.warning_enable);
  endproperty
  a_warn_mute: assert property (p_warn_mute) else $error("warning pulse while warnings disabled");

  c_split_jump: cover property (exec_read && ctrl.split_mode && ptr[2:0] == `VSBT_HALF_TOP);
  c_expired_xfer: cover property (xfer_ok && row_expired && ctrl.half_size);
  c_masked_xfer: cover property (xfer_ok && cmd.write_per_bit);
  c_warning: cover property (warn_pulse);

endmodule

/* rtl/vsbt_pkg.sv */
package vsbt_pkg;

  typedef enum logic [1:0] {
    SEG_FULL = 2'h0,
    SEG_LOWER = 2'h1,
    SEG_UPPER = 2'h2
  } segment_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_type;

  typedef struct packed {
    logic [27:0] reserved;
    logic is_vram;
    logic warning_enable;
    logic half_size;
    logic split_mode;
  } ctrl_type;

  typedef struct packed {
    logic [3:0] row_unknown;
    logic [2:0] row_len;
    logic [6:0] row_vec;
    logic [4:0] reserved;
    logic [4:0] serial_ptr;
    logic [2:0] reserved2;
    logic [1:0] row_segment;
    logic write_per_bit;
    logic go_transfer;
    logic go_read;
  } command_type;

  typedef struct packed {
    logic [10:0] reserved;
    logic [4:0] out_width;
    logic [6:0] reserved2;
    logic data_fill;
    logic [3:0] reserved3;
    logic [3:0] addr_fill;
  } subst_type;

  typedef struct packed {
    logic [19:0] reserved;
    logic [3:0] index;
    logic [7:0] data;
  } sam_load_type;

  typedef struct packed {
    logic [23:0] reserved;
    logic [3:0] row;
    logic [3:0] word;
  } peek_type;

  typedef struct packed {
    logic [21:0] reserved;
    logic bad_segment;
    logic not_vram;
    logic row_mapped;
    logic row_too_wide;
    logic row_expired;
    logic asleep;
    logic ptr_clamped;
    logic seg_forced;
    logic data_mapped;
    logic bad_width;
  } event_type;

endpackage

/* rtl/vsbt_regs.svh */
`ifndef VSBT_REGS_SVH
`define VSBT_REGS_SVH

// ===========================================================================
// register byte offsets
`define VSBT_OFF_CTRL 8'h00
`define VSBT_OFF_CMD 8'h04
`define VSBT_OFF_WMASK 8'h08
`define VSBT_OFF_SUBST 8'h0C
`define VSBT_OFF_SAMLD 8'h10
`define VSBT_OFF_STATUS 8'h14
`define VSBT_OFF_RDATA 8'h18
`define VSBT_OFF_PEEK 8'h1C
`define VSBT_OFF_EVENT 8'h20

// ===========================================================================
// reset values
`define VSBT_CTRL_RESET 32'h0000000C
`define VSBT_SUBST_RESET 32'h00080000
`define VSBT_WMASK_RESET 8'hFF

// ===========================================================================
// geometry
`define VSBT_SAM_WORDS 16
`define VSBT_HALF_WORDS 8
`define VSBT_ROWS 16
`define VSBT_ROW_BITS 4
`define VSBT_WORD_BITS 8
`define VSBT_OUT_BITS 16
`define VSBT_SAM_TOP 4'hF
`define VSBT_HALF_TOP 3'h7
`define VSBT_LOWER_BASE 4'h0
`define VSBT_UPPER_BASE 4'h8
`define VSBT_ROW_LEN_NEEDED 3'h4
`define VSBT_OUT_NATIVE 5'h08
`define VSBT_AGE_MAX 3'h7

// ===========================================================================
// timing
`define VSBT_CLK_NS 10
`define VSBT_WAKE_NS 2000
`define VSBT_REFRESH_TICK_NS 2560

// ===========================================================================
// bus answers
`define VSBT_RESP_OKAY 2'h0
`define VSBT_RESP_SLVERR 2'h2

`endif

/* verif/vram_serial_buffer_transfer_test.sv */
`include "vsbt_regs.svh"

module vram_serial_buffer_transfer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vsbt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic warn_pulse, error_pulse;
  event_type last_event;
  int miscompares = 0;
  int samples_checked = 0;
  int warns = 0;
  int errs = 0;
  always #5 aclk = ~aclk;
  // counting high cycles means a stretched pulse shows as an extra event
  always @(posedge aclk) warns <= warns + (warn_pulse === 1'b1);
  always @(posedge aclk) errs <= errs + (error_pulse === 1'b1);
  vram_serial_buffer_transfer DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .warn_pulse, .error_pulse, .last_event);
  vsbt_ctrl_model ctrl (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  // ==========
  // helpers
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
    ctrl.rd(a, d, r);
    check(d & m, want);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    ctrl.wr(a, v, r);
  endtask
  // row 3 given as a four-bit field, msb on the left
  function logic [31:0] xfer(input logic [4:0] p, input logic [1:0] seg, input logic wpb);
    return {4'h0, 3'h4, 7'h03, 5'h00, p, 3'h0, seg, wpb, 2'h2};
  endfunction
  // cause bits are read back over the bus and also taken straight off the port
  task cmd(input logic [31:0] c, input logic [31:0] ev, input int w, input int e);
    int w0;
    int e0;
    w0 = warns;
    e0 = errs;
    wr(`VSBT_OFF_CMD, c);
    repeat (3) @(posedge aclk);
    rchk(`VSBT_OFF_EVENT, 32'h3FF, ev);
    check(last_event & 32'h3FF, ev);
    check(warns - w0, w);
    check(errs - e0, e);
  endtask
  // ==========
  // scenarios
  task t_regs;
    rchk(`VSBT_OFF_CTRL, 32'hFFFFFFFF, `VSBT_CTRL_RESET);
    rchk(`VSBT_OFF_WMASK, 32'hFF, 32'hFF);
    rchk(`VSBT_OFF_SUBST, 32'hFFFFFFFF, `VSBT_SUBST_RESET);
    ctrl.rd(8'h40, d, r);
    check(r, `VSBT_RESP_SLVERR);
    ctrl.wr(8'h40, 32'h0, r);
    check(r, `VSBT_RESP_SLVERR);
  endtask
  task t_asleep;
    cmd(xfer(5'h09, SEG_FULL, 1'b0), 32'h10, 1, 0);
    wr(`VSBT_OFF_PEEK, 32'h35);
    rchk(`VSBT_OFF_PEEK, 32'h100, 32'h0);
  endtask
  task t_split_read;
    for (int i = 0; i < 16; i++) wr(`VSBT_OFF_SAMLD, 32'hA0 + i * 32'h101);
    wr(`VSBT_OFF_CTRL, 32'h0D);
    for (int i = 0; i < 8; i++) begin
      cmd(32'h080C0001, 32'h0, 0, 0);
      rchk(`VSBT_OFF_RDATA, 32'hFFFF, 32'hA0 + i);
    end
    rchk(`VSBT_OFF_STATUS, 32'hF, 32'h8);
  endtask
  task t_transfer;
    wr(`VSBT_OFF_CTRL, 32'h0C);
    cmd(xfer(5'h09, SEG_FULL, 1'b0), 32'h0, 0, 0);
    wr(`VSBT_OFF_PEEK, 32'h35);
    rchk(`VSBT_OFF_PEEK, 32'h1FF, 32'h1A5);
    rchk(`VSBT_OFF_STATUS, 32'hF000F, 32'h90009);
    cmd(xfer(5'h14, SEG_FULL, 1'b0), 32'h08, 1, 0);
    rchk(`VSBT_OFF_STATUS, 32'hF000F, 32'hF000F);
    cmd(32'h080C0001, 32'h0, 0, 0);
    rchk(`VSBT_OFF_RDATA, 32'hFFFF, 32'hAF);
    rchk(`VSBT_OFF_STATUS, 32'hF000F, 32'h80000);
  endtask
  task t_forced_mask;
    cmd(xfer(5'h00, SEG_LOWER, 1'b0), 32'h04, 1, 0);
    wr(`VSBT_OFF_PEEK, 32'h3C);
    rchk(`VSBT_OFF_PEEK, 32'h1FF, 32'h1AC);
    wr(`VSBT_OFF_WMASK, 32'h0F);
    wr(`VSBT_OFF_SAMLD, 32'h5A);
    cmd(xfer(5'h00, SEG_FULL, 1'b1), 32'h0, 0, 0);
    wr(`VSBT_OFF_PEEK, 32'h30);
    rchk(`VSBT_OFF_PEEK, 32'h1FF, 32'h1AA);
  endtask
  task t_errors;
    wr(`VSBT_OFF_CTRL, 32'h04);
    cmd(xfer(5'h00, SEG_FULL, 1'b0), 32'h100, 0, 1);
    wr(`VSBT_OFF_CTRL, 32'h08);
    cmd(xfer(5'h14, SEG_FULL, 1'b0), 32'h08, 0, 0);
  endtask
  // half-size buffer: segment check, expired rows, row vector mapping, wide output
  task t_half;
    wr(`VSBT_OFF_CTRL, 32'h0E);
    cmd(xfer(5'h00, SEG_FULL, 1'b0), 32'h200, 0, 1);
    // long enough for every row to reach the expiry mark
    repeat (1800) @(posedge aclk);
    cmd(32'h0A4C0012, 32'h60, 1, 0);
    wr(`VSBT_OFF_PEEK, 32'h3A);
    rchk(`VSBT_OFF_PEEK, 32'h1FF, 32'h1A2);
    wr(`VSBT_OFF_PEEK, 32'h31);
    rchk(`VSBT_OFF_PEEK, 32'h100, 32'h0);
    wr(`VSBT_OFF_SUBST, 32'h0008010C);
    cmd(32'h0404000A, 32'hA0, 1, 0);
    wr(`VSBT_OFF_PEEK, 32'hD3);
    rchk(`VSBT_OFF_PEEK, 32'h1FF, 32'h1A3);
    wr(`VSBT_OFF_SUBST, 32'h000C0100);
    cmd(32'h080C0001, 32'h03, 1, 0);
    rchk(`VSBT_OFF_RDATA, 32'hFFFF, 32'hF5A);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_asleep;
    t_split_read;
    repeat (200) @(posedge aclk);
    t_transfer;
    t_forced_mask;
    t_errors;
    t_half;
    complete_run;
  end
  initial begin
    #50us;
    miscompares++;
    complete_run;
  end
endmodule

/* verif/vsbt_ctrl_model.sv */
module vsbt_ctrl_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // ==========
  // bus cycles
  // each channel drops its valid only once its own ready was seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok || awready === 1'b1;
      w_ok = w_ok || wready === 1'b1;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
